/* verilog/tlic_pkg.sv */
package tlic_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int INSTR_CYCLE_NS = 200;
    localparam int CLKS_PER_INSTR =
        (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_W = 8;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PC_W = 21;
    localparam int STACK_DEPTH = 2;
    localparam int SP_W = 2;
    localparam int NUM_PREGS = 5;
    localparam int NUM_EXT = 4;
    localparam int NUM_PORT = 4;
    localparam int NUM_CORE_SRC = 6;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_RESET_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CTRL = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CTRL2 = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CTRL3 = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_FLAG_BASE = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_ENABLE_BASE = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_PRIO_BASE = 8'h38;
    localparam logic [ADDR_W-1:0] BANK_SPAN = 8'h14;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_PRIO_MODE = 7;
    localparam int BIT_GLOBAL_HIGH = 7;
    localparam int BIT_GLOBAL_LOW = 6;
    localparam int BIT_TMR_EN = 5;
    localparam int BIT_EXT0_EN = 4;
    localparam int BIT_PORT_EN = 3;
    localparam int BIT_TMR_FLAG = 2;
    localparam int BIT_EXT0_FLAG = 1;
    localparam int BIT_PORT_FLAG = 0;
    localparam int BIT_EDGE0 = 6;
    localparam int BIT_TMR_PRIO = 2;
    localparam int BIT_EXT3_PRIO = 1;
    localparam int BIT_PORT_PRIO = 0;
    localparam int BIT_EXT2_PRIO = 7;
    localparam int BIT_EXT1_PRIO = 6;
    localparam int BIT_EXT1_EN = 3;
    localparam int BIT_EXT1_FLAG = 0;

    // ------------------------------------------------------------
    // reset values and constants
    // ------------------------------------------------------------
    localparam logic [7:0] RST_RESET_CTRL = 8'h00;
    localparam logic [7:0] RST_IRQ_CTRL = 8'h00;
    localparam logic [7:0] RST_IRQ_CTRL2 = 8'hFF;
    localparam logic [7:0] RST_IRQ_CTRL3 = 8'hC0;
    localparam logic [7:0] RST_FLAG = 8'h00;
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_PRIO = 8'hFF;
    localparam logic [NUM_PREGS-1:0][7:0] PREG_MASK =
        {8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    localparam logic [PC_W-1:0] VEC_HIGH = 21'h0_0008;
    localparam logic [PC_W-1:0] VEC_LOW = 21'h0_0018;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } tlic_axi_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } tlic_axi_rsp_type;

    typedef struct packed {
        logic [PC_W-1:0] return_addr;
        logic return_from_service;
        logic low_power_mode;
    } tlic_core_in_type;

    typedef struct packed {
        logic pc_load;
        logic [PC_W-1:0] pc_value;
        logic req_high;
        logic req_low;
        logic wake_request;
        logic in_service_high;
        logic in_service_low;
    } tlic_core_out_type;

    typedef struct packed {
        logic [NUM_PREGS-1:0][7:0] periph_event;
        logic timer_overflow;
        logic [NUM_EXT-1:0] ext_pin;
        logic [NUM_PORT-1:0] port_pin;
    } tlic_event_in_type;
endpackage

/* verilog/tlic_top.sv */
// Register access over AXI4-Lite and the address map were decided locally.
module tlic_top #(
    parameter int CLKS_PER_INSTR = tlic_pkg::CLKS_PER_INSTR
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire tlic_pkg::tlic_axi_req_type AXI_REQ,
    output tlic_pkg::tlic_axi_rsp_type AXI_RSP,
    input wire tlic_pkg::tlic_core_in_type CORE_IN,
    output tlic_pkg::tlic_core_out_type CORE_OUT,
    input wire tlic_pkg::tlic_event_in_type EVENTS
);
    import tlic_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] reset_control_reg;
        logic [7:0] irq_control_reg;
        logic [7:0] irq_control2_reg;
        logic [7:0] irq_control3_reg;
        logic [NUM_PREGS-1:0][7:0] peripheral_flag_reg;
        logic [NUM_PREGS-1:0][7:0] peripheral_enable_reg;
        logic [NUM_PREGS-1:0][7:0] peripheral_priority_reg;
        logic [NUM_EXT-1:0] ext_s1;
        logic [NUM_EXT-1:0] ext_s2;
        logic [NUM_EXT-1:0] ext_prev;
        logic [NUM_PORT-1:0] port_s1;
        logic [NUM_PORT-1:0] port_s2;
        logic [NUM_PORT-1:0] port_prev;
        logic [TICK_W-1:0] tick_cnt;
        logic req_high;
        logic req_low;
        logic arm_high;
        logic arm_low;
        logic wake_request;
        logic pc_load;
        logic [PC_W-1:0] pc_value;
        logic in_service_high;
        logic in_service_low;
        logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
        logic [SP_W-1:0] sp;
        logic aw_have;
        logic [ADDR_W-1:0] aw_addr;
        logic w_have;
        logic [DATA_W-1:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } tlic_state_type;

    localparam logic [TICK_W-1:0] TICK_LAST =
        TICK_W'(CLKS_PER_INSTR - 1);
    localparam logic [SP_W-1:0] SP_FULL = SP_W'(STACK_DEPTH);

    tlic_state_type s_q;
    tlic_state_type s_d;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    // a bank is one of flag, enable or priority: five words each
    function automatic logic in_bank(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] base
    );
        logic [ADDR_W-1:0] diff;
        diff = addr - base;
        return (addr >= base) && (diff < BANK_SPAN) &&
            (diff[1:0] == 2'b00);
    endfunction

    function automatic logic [2:0] bank_idx(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] base
    );
        logic [ADDR_W-1:0] diff;
        diff = addr - base;
        return diff[4:2];
    endfunction

    function automatic logic [8:0] read_reg(
        input tlic_state_type st,
        input logic [ADDR_W-1:0] addr
    );
        logic [2:0] ix;
        ix = 3'd0;
        if (addr == OFS_RESET_CTRL) begin
            return {1'b1, st.reset_control_reg};
        end
        if (addr == OFS_IRQ_CTRL) begin
            return {1'b1, st.irq_control_reg};
        end
        if (addr == OFS_IRQ_CTRL2) begin
            return {1'b1, st.irq_control2_reg};
        end
        if (addr == OFS_IRQ_CTRL3) begin
            return {1'b1, st.irq_control3_reg};
        end
        if (in_bank(addr, OFS_FLAG_BASE)) begin
            ix = bank_idx(addr, OFS_FLAG_BASE);
            return {1'b1, st.peripheral_flag_reg[ix] & PREG_MASK[ix]};
        end
        if (in_bank(addr, OFS_ENABLE_BASE)) begin
            ix = bank_idx(addr, OFS_ENABLE_BASE);
            return {1'b1, st.peripheral_enable_reg[ix] & PREG_MASK[ix]};
        end
        if (in_bank(addr, OFS_PRIO_BASE)) begin
            ix = bank_idx(addr, OFS_PRIO_BASE);
            return {1'b1,
                st.peripheral_priority_reg[ix] & PREG_MASK[ix]};
        end
        return 9'h000;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [8:0] rd;
        logic [7:0] wb;
        logic [2:0] ix;
        logic hit;
        logic tick;
        logic prio_mode;
        logic [NUM_EXT-1:0] ext_evt;
        logic port_evt;
        logic [NUM_CORE_SRC-1:0] c_flag;
        logic [NUM_CORE_SRC-1:0] c_en;
        logic [NUM_CORE_SRC-1:0] c_prio;
        logic [NUM_PREGS-1:0][7:0] p_act;
        logic any_high;
        logic any_low;
        logic any_core;
        logic any_periph;
        logic any_pending;
        logic high_ok;
        logic low_ok;
        logic high_c;
        logic low_c;
        rd = 9'h000;
        wb = 8'h00;
        ix = 3'd0;
        hit = 1'b0;
        ext_evt = '0;
        p_act = '0;
        tick = 1'b0;
        prio_mode = 1'b0;
        port_evt = 1'b0;
        c_flag = '0;
        c_en = '0;
        c_prio = '0;
        any_high = 1'b0;
        any_low = 1'b0;
        any_core = 1'b0;
        any_periph = 1'b0;
        any_pending = 1'b0;
        high_ok = 1'b0;
        low_ok = 1'b0;
        high_c = 1'b0;
        low_c = 1'b0;
        s_d = s_q;
        s_d.pc_load = 1'b0;

        // instruction cycle strobe
        tick = (s_q.tick_cnt == TICK_LAST);
        s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + TICK_W'(1);

        // pins are asynchronous: two stages before use
        s_d.ext_s1 = EVENTS.ext_pin;
        s_d.ext_s2 = s_q.ext_s1;
        s_d.ext_prev = s_q.ext_s2;
        s_d.port_s1 = EVENTS.port_pin;
        s_d.port_s2 = s_q.port_s1;
        s_d.port_prev = s_q.port_s2;
        for (int i = 0; i < NUM_EXT; i++) begin
            ext_evt[i] = s_q.irq_control2_reg[BIT_EDGE0 - i] ?
                (s_q.ext_s2[i] & ~s_q.ext_prev[i]) :
                (~s_q.ext_s2[i] & s_q.ext_prev[i]);
        end
        port_evt = |(s_q.port_s2 ^ s_q.port_prev);

        // write channel: address and data in either order
        if (AXI_REQ.awvalid && s_q.awready) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = AXI_REQ.awaddr;
        end
        if (AXI_REQ.wvalid && s_q.wready) begin
            s_d.w_have = 1'b1;
            s_d.w_data = AXI_REQ.wdata;
            s_d.w_strb = AXI_REQ.wstrb;
        end
        if (s_q.bvalid && AXI_REQ.bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
            wb = s_q.w_data[7:0];
            hit = 1'b1;
            // only byte lane 0 carries register bits
            if (s_q.aw_addr == OFS_RESET_CTRL) begin
                if (s_q.w_strb[0]) s_d.reset_control_reg = wb;
            end else if (s_q.aw_addr == OFS_IRQ_CTRL) begin
                if (s_q.w_strb[0]) s_d.irq_control_reg = wb;
            end else if (s_q.aw_addr == OFS_IRQ_CTRL2) begin
                if (s_q.w_strb[0]) s_d.irq_control2_reg = wb;
            end else if (s_q.aw_addr == OFS_IRQ_CTRL3) begin
                if (s_q.w_strb[0]) s_d.irq_control3_reg = wb;
            end else if (in_bank(s_q.aw_addr, OFS_FLAG_BASE)) begin
                ix = bank_idx(s_q.aw_addr, OFS_FLAG_BASE);
                if (s_q.w_strb[0]) begin
                    s_d.peripheral_flag_reg[ix] = wb & PREG_MASK[ix];
                end
            end else if (in_bank(s_q.aw_addr, OFS_ENABLE_BASE)) begin
                ix = bank_idx(s_q.aw_addr, OFS_ENABLE_BASE);
                if (s_q.w_strb[0]) begin
                    s_d.peripheral_enable_reg[ix] = wb & PREG_MASK[ix];
                end
            end else if (in_bank(s_q.aw_addr, OFS_PRIO_BASE)) begin
                ix = bank_idx(s_q.aw_addr, OFS_PRIO_BASE);
                if (s_q.w_strb[0]) begin
                    s_d.peripheral_priority_reg[ix] =
                        wb & PREG_MASK[ix];
                end
            end else begin
                hit = 1'b0;
            end
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = hit ? RESP_OKAY : RESP_SLVERR;
        end

        // events after the write: a set beats a same-cycle clear
        s_d.peripheral_flag_reg = s_d.peripheral_flag_reg |
            (EVENTS.periph_event & PREG_MASK);
        if (EVENTS.timer_overflow) begin
            s_d.irq_control_reg[BIT_TMR_FLAG] = 1'b1;
        end
        if (ext_evt[0]) begin
            s_d.irq_control_reg[BIT_EXT0_FLAG] = 1'b1;
        end
        if (port_evt) begin
            s_d.irq_control_reg[BIT_PORT_FLAG] = 1'b1;
        end
        for (int i = 1; i < NUM_EXT; i++) begin
            if (ext_evt[i]) begin
                s_d.irq_control3_reg[BIT_EXT1_FLAG + i - 1] = 1'b1;
            end
        end

        // per-source flag, enable, priority (order: tmr, ext0..3, port)
        c_flag = {s_q.irq_control_reg[BIT_PORT_FLAG],
            s_q.irq_control3_reg[BIT_EXT1_FLAG + 2],
            s_q.irq_control3_reg[BIT_EXT1_FLAG + 1],
            s_q.irq_control3_reg[BIT_EXT1_FLAG],
            s_q.irq_control_reg[BIT_EXT0_FLAG],
            s_q.irq_control_reg[BIT_TMR_FLAG]};
        c_en = {s_q.irq_control_reg[BIT_PORT_EN],
            s_q.irq_control3_reg[BIT_EXT1_EN + 2],
            s_q.irq_control3_reg[BIT_EXT1_EN + 1],
            s_q.irq_control3_reg[BIT_EXT1_EN],
            s_q.irq_control_reg[BIT_EXT0_EN],
            s_q.irq_control_reg[BIT_TMR_EN]};
        // the first pin has no priority bit and is always high
        c_prio = {s_q.irq_control2_reg[BIT_PORT_PRIO],
            s_q.irq_control2_reg[BIT_EXT3_PRIO],
            s_q.irq_control3_reg[BIT_EXT2_PRIO],
            s_q.irq_control3_reg[BIT_EXT1_PRIO],
            1'b1,
            s_q.irq_control2_reg[BIT_TMR_PRIO]};
        p_act = s_q.peripheral_flag_reg & s_q.peripheral_enable_reg &
            PREG_MASK;
        any_core = |(c_flag & c_en);
        any_periph = |p_act;
        any_high = |(c_flag & c_en & c_prio) |
            |(p_act & s_q.peripheral_priority_reg);
        any_low = |(c_flag & c_en & ~c_prio) |
            |(p_act & ~s_q.peripheral_priority_reg);
        any_pending = any_core | any_periph;

        prio_mode = s_q.reset_control_reg[BIT_PRIO_MODE];
        high_ok = s_q.irq_control_reg[BIT_GLOBAL_HIGH];
        low_ok = s_q.irq_control_reg[BIT_GLOBAL_LOW];
        if (prio_mode) begin
            high_c = any_high & high_ok;
            // high routine in progress keeps low requests out
            low_c = any_low & high_ok & low_ok &
                ~s_q.in_service_high;
        end else begin
            // priority bits unused; everything goes high
            high_c = high_ok & (any_core | (low_ok & any_periph));
            low_c = 1'b0;
        end

        if (tick) begin
            s_d.req_high = high_c;
            s_d.req_low = low_c;
            // one more held tick stretches pin latency to 3..4 ticks
            s_d.arm_high = s_q.req_high & high_c;
            s_d.arm_low = s_q.req_low & low_c;
        end
        s_d.wake_request = CORE_IN.low_power_mode & any_pending;

        // return beats a vector in the same cycle
        if (CORE_IN.return_from_service) begin
            s_d.pc_load = 1'b1;
            if (s_q.sp != '0) begin
                s_d.pc_value = s_q.stack[s_q.sp - SP_W'(1)];
                s_d.sp = s_q.sp - SP_W'(1);
            end
            if (s_q.in_service_high) begin
                s_d.in_service_high = 1'b0;
                s_d.irq_control_reg[BIT_GLOBAL_HIGH] = 1'b1;
            end else if (s_q.in_service_low) begin
                s_d.in_service_low = 1'b0;
                s_d.irq_control_reg[BIT_GLOBAL_LOW] = 1'b1;
            end else begin
                s_d.irq_control_reg[BIT_GLOBAL_HIGH] = 1'b1;
            end
        end else if (tick && s_q.arm_high && high_c) begin
            s_d.pc_load = 1'b1;
            s_d.pc_value = VEC_HIGH;
            s_d.in_service_high = 1'b1;
            s_d.irq_control_reg[BIT_GLOBAL_HIGH] = 1'b0;
            s_d.req_high = 1'b0;
            s_d.arm_high = 1'b0;
            // a full stack drops the push; depth limits nesting
            if (s_q.sp != SP_FULL) begin
                s_d.stack[s_q.sp] = CORE_IN.return_addr;
                s_d.sp = s_q.sp + SP_W'(1);
            end
        end else if (tick && s_q.arm_low && low_c) begin
            s_d.pc_load = 1'b1;
            s_d.pc_value = VEC_LOW;
            s_d.in_service_low = 1'b1;
            s_d.irq_control_reg[BIT_GLOBAL_LOW] = 1'b0;
            s_d.req_low = 1'b0;
            s_d.arm_low = 1'b0;
            if (s_q.sp != SP_FULL) begin
                s_d.stack[s_q.sp] = CORE_IN.return_addr;
                s_d.sp = s_q.sp + SP_W'(1);
            end
        end

        // read channel
        if (AXI_REQ.arvalid && s_q.arready) begin
            rd = read_reg(s_q, AXI_REQ.araddr);
            s_d.rvalid = 1'b1;
            s_d.rdata = {24'h00_0000, rd[7:0]};
            s_d.rresp = rd[8] ? RESP_OKAY : RESP_SLVERR;
        end else if (s_q.rvalid && AXI_REQ.rready) begin
            s_d.rvalid = 1'b0;
        end

        s_d.awready = ~s_d.aw_have & ~s_d.bvalid;
        s_d.wready = ~s_d.w_have & ~s_d.bvalid;
        s_d.arready = ~s_d.rvalid;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            s_q <= '0;
            s_q.reset_control_reg <= RST_RESET_CTRL;
            s_q.irq_control_reg <= RST_IRQ_CTRL;
            s_q.irq_control2_reg <= RST_IRQ_CTRL2;
            s_q.irq_control3_reg <= RST_IRQ_CTRL3;
            s_q.peripheral_flag_reg <= {NUM_PREGS{RST_FLAG}};
            s_q.peripheral_enable_reg <= {NUM_PREGS{RST_ENABLE}};
            s_q.peripheral_priority_reg <= {NUM_PREGS{RST_PRIO}};
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb begin
        AXI_RSP.awready = s_q.awready;
        AXI_RSP.wready = s_q.wready;
        AXI_RSP.bresp = s_q.bresp;
        AXI_RSP.bvalid = s_q.bvalid;
        AXI_RSP.arready = s_q.arready;
        AXI_RSP.rdata = s_q.rdata;
        AXI_RSP.rresp = s_q.rresp;
        AXI_RSP.rvalid = s_q.rvalid;
        CORE_OUT.pc_load = s_q.pc_load;
        CORE_OUT.pc_value = s_q.pc_value;
        CORE_OUT.req_high = s_q.req_high;
        CORE_OUT.req_low = s_q.req_low;
        CORE_OUT.wake_request = s_q.wake_request;
        CORE_OUT.in_service_high = s_q.in_service_high;
        CORE_OUT.in_service_low = s_q.in_service_low;
    end
endmodule

/* test/tlic_checker.sv */
module tlic_checker
    import tlic_pkg::*;
#(
    parameter int CLKS_PER_INSTR = 4
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire tlic_pkg::tlic_axi_req_type AXI_REQ,
    input wire tlic_pkg::tlic_axi_rsp_type AXI_RSP,
    input wire tlic_pkg::tlic_core_in_type CORE_IN,
    input wire tlic_pkg::tlic_core_out_type CORE_OUT,
    input wire tlic_pkg::tlic_event_in_type EVENTS
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);
    sequence s_ret;
        CORE_IN.return_from_service ##1 CORE_OUT.pc_load;
    endsequence
    property p_vec_high;
        $rose(CORE_OUT.in_service_high) |->
            CORE_OUT.pc_load && CORE_OUT.pc_value == VEC_HIGH;
    endproperty
    a_vec_high: assert property (p_vec_high)
        else $error("high entry without vector load");
    property p_vec_low;
        $rose(CORE_OUT.in_service_low) |->
            CORE_OUT.pc_load && CORE_OUT.pc_value == VEC_LOW;
    endproperty
    a_vec_low: assert property (p_vec_low)
        else $error("low entry without vector load");
    property p_no_low;
        $rose(CORE_OUT.in_service_low) |-> !$past(CORE_OUT.in_service_high);
    endproperty
    a_no_low: assert property (p_no_low)
        else $error("low entry during high routine");
    property p_ret;
        CORE_IN.return_from_service |-> s_ret;
    endproperty
    a_ret: assert property (p_ret)
        else $error("return without load");
    property p_ret_high;
        CORE_IN.return_from_service && CORE_OUT.in_service_high |=>
            !CORE_OUT.in_service_high;
    endproperty
    a_ret_high: assert property (p_ret_high)
        else $error("high routine not left on return");
    property p_wake;
        !CORE_IN.low_power_mode |=> !CORE_OUT.wake_request;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake request while awake");
    property p_req_high;
        $rose(CORE_OUT.in_service_high) |-> $past(CORE_OUT.req_high);
    endproperty
    a_req_high: assert property (p_req_high)
        else $error("high entry without registered request");
    property p_req_low;
        $rose(CORE_OUT.in_service_low) |-> $past(CORE_OUT.req_low);
    endproperty
    a_req_low: assert property (p_req_low)
        else $error("low entry without registered request");
    property p_b_time;
        AXI_REQ.awvalid && AXI_RSP.awready && AXI_REQ.wvalid
            && AXI_RSP.wready |-> ##[2:3] AXI_RSP.bvalid;
    endproperty
    a_b_time: assert property (p_b_time)
        else $error("write response late");
    property p_r_time;
        AXI_REQ.arvalid && AXI_RSP.arready |-> ##[1:2] AXI_RSP.rvalid;
    endproperty
    a_r_time: assert property (p_r_time)
        else $error("read response late");
endmodule
bind tlic_top tlic_checker #(
    .CLKS_PER_INSTR(CLKS_PER_INSTR)
) u_chk (
    .CLK(CLK),
    .RESETN(RESETN),
    .AXI_REQ(AXI_REQ),
    .AXI_RSP(AXI_RSP),
    .CORE_IN(CORE_IN),
    .CORE_OUT(CORE_OUT),
    .EVENTS(EVENTS)
);

/* test/tlic_core_model.sv */
module tlic_core_model
    import tlic_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire tlic_pkg::tlic_core_out_type core_out,
    input wire logic ret_go,
    input wire logic sleep,
    output tlic_pkg::tlic_core_in_type core_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [PC_W-1:0] pc_q;
    // a running pc so each push carries a fresh address
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pc_q <= 21'h0_0100;
        end else if (core_out.pc_load) begin
            pc_q <= core_out.pc_value;
        end else begin
            pc_q <= pc_q + 21'h0_0001;
        end
    end
    assign core_in.return_addr = pc_q;
    assign core_in.return_from_service = ret_go;
    assign core_in.low_power_mode = sleep;
endmodule

/* test/tlic_tb_top.sv */
module tlic_tb_top
    import tlic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk;
    logic rstn;
    tlic_axi_req_type req;
    tlic_axi_rsp_type rsp;
    tlic_core_in_type cin;
    tlic_core_out_type cout;
    tlic_event_in_type ev;
    logic ret_go;
    logic sleep;
    int miscompares;
    int comparisons;
    int n;
    tlic_top #(.CLKS_PER_INSTR(4)) u_dut (.CLK(clk), .RESETN(rstn),
        .AXI_REQ(req), .AXI_RSP(rsp), .CORE_IN(cin), .CORE_OUT(cout),
        .EVENTS(ev));
    tlic_core_model u_core (.clk(clk), .rstn(rstn), .core_out(cout),
        .ret_go(ret_go), .sleep(sleep), .core_in(cin));
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    task automatic close_out();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // every polling wait goes through here, so no polling wait can hang
    task automatic step();
        @(posedge clk);
        n++;
        if (n > 60) begin
            miscompares++;
            $display("unexpected at %0t: timeout", $time);
            close_out();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] e);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'h1;
        req.wvalid <= 1'h1;
        req.bready <= 1'h1;
        n = 0;
        do begin
            step();
            if (rsp.awready)
                req.awvalid <= 1'h0;
            if (rsp.wready)
                req.wvalid <= 1'h0;
        end while (!rsp.bvalid);
        req.bready <= 1'h0;
        chk(32'(rsp.bresp), 32'(e));
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] r);
        req.araddr <= a;
        req.arvalid <= 1'h1;
        req.rready <= 1'h1;
        n = 0;
        do begin
            step();
            if (rsp.arready)
                req.arvalid <= 1'h0;
        end while (!rsp.rvalid);
        req.rready <= 1'h0;
        chk(rsp.rdata, e);
        chk(32'(rsp.rresp), 32'(r));
        @(posedge clk);
    endtask
    task automatic wl();
        n = 0;
        do step(); while (!cout.pc_load);
    endtask
    task automatic ret();
        ret_go <= 1'h1;
        @(posedge clk);
        ret_go <= 1'h0;
        wl();
    endtask
    initial begin
        req = '0;
        ev = '0;
        ret_go = 1'h0;
        sleep = 1'h0;
        rstn = 1'h0;
        repeat (10) @(posedge clk);
        rstn <= 1'h1;
        repeat (2) @(posedge clk);
        rd(OFS_RESET_CTRL, 32'h0000_0000, RESP_OKAY);
        rd(OFS_IRQ_CTRL3, 32'h0000_00C0, RESP_OKAY);
        rd(8'h48, 32'h0000_003F, RESP_OKAY);
        rd(8'h4C, 32'h0000_0000, RESP_SLVERR);
        wr(8'h4C, 32'h0000_0001, RESP_SLVERR);
        $display("reset test done");
        wr(OFS_IRQ_CTRL, 32'h0000_0090, RESP_OKAY);
        ev.ext_pin[0] <= 1'h1;
        wl();
        chk(32'(cout.pc_value), 32'(VEC_HIGH));
        // load is seen one edge late; 3..4 instructions of 4 clocks
        chk(32'(n >= 13 && n <= 17), 32'h0000_0001);
        rd(OFS_IRQ_CTRL, 32'h0000_0012, RESP_OKAY);
        wr(OFS_IRQ_CTRL, 32'h0000_0010, RESP_OKAY);
        ret();
        rd(OFS_IRQ_CTRL, 32'h0000_0090, RESP_OKAY);
        $display("single level test done");
        wr(OFS_RESET_CTRL, 32'h0000_0080, RESP_OKAY);
        wr(OFS_IRQ_CTRL2, 32'h0000_00FB, RESP_OKAY);
        wr(OFS_IRQ_CTRL, 32'h0000_00E0, RESP_OKAY);
        ev.timer_overflow <= 1'h1;
        @(posedge clk);
        ev.timer_overflow <= 1'h0;
        wl();
        chk(32'(cout.pc_value), 32'(VEC_LOW));
        rd(OFS_IRQ_CTRL, 32'h0000_00A4, RESP_OKAY);
        ev.ext_pin[0] <= 1'h0;
        wr(OFS_IRQ_CTRL, 32'h0000_00B0, RESP_OKAY);
        ev.ext_pin[0] <= 1'h1;
        wl();
        chk(32'(cout.pc_value), 32'(VEC_HIGH));
        chk(32'(cout.in_service_low), 32'h0000_0001);
        wr(OFS_IRQ_CTRL, 32'h0000_0030, RESP_OKAY);
        ret();
        ret();
        rd(OFS_IRQ_CTRL, 32'h0000_00F0, RESP_OKAY);
        $display("two level test done");
        wr(OFS_IRQ_CTRL, 32'h0000_0020, RESP_OKAY);
        sleep <= 1'h1;
        ev.timer_overflow <= 1'h1;
        ev.periph_event[0][0] <= 1'h1;
        ev.port_pin[1] <= 1'h1;
        @(posedge clk);
        ev.timer_overflow <= 1'h0;
        ev.periph_event[0][0] <= 1'h0;
        repeat (3) @(posedge clk);
        chk(32'(cout.wake_request), 32'h0000_0001);
        rd(OFS_IRQ_CTRL, 32'h0000_0025, RESP_OKAY);
        rd(OFS_FLAG_BASE, 32'h0000_0001, RESP_OKAY);
        $display("wake test done");
        close_out();
    end
endmodule
